/* core/sfc_frame_ctrl.sv */
`timescale 1ns/100ps
// Behaviour
// - one word: 24 data plus 3 controls
// - high marker set, low marker cleared
// - 26 payload bits are scrambled, balanced
// - 28 serial bit times per clock
// - line rate 140 Mbps to 1.4 Gbps
// - lock on any pattern, no training
// - extract markers, validate, then deserialize
// - 24-bit mode carries controls encoded
// - 18-bit mode adds six general signals
// - mode pins decode filter and legacy modes
// - mode also gates control filter
// - mode from pins only, ends matched
// - legacy modes per earlier family
// - filter on: 2 per 130, pulse>=3
// - filter off: 2 per 130 only
// - control three: 1 per 130
// - filter suppresses glitches on controls one and two
// - serializer generates self-test pattern
module sfc_frame_ctrl (
  // Clock and control
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clkEn,
  // Mode straps (pins)
  input  wire logic [1:0]                 modePins,
  input  wire logic                       colorDepth18,
  input  wire logic                       selfTestEn,
  // Parallel input
  input  wire sfc_pkg::sfc_word_t         txWord,
  input  wire logic [5:0]                 txGpio,
  input  wire logic                       txValid,
  output logic                            txReady,
  // Serial word out
  output logic [sfc_pkg::WORD_BITS-1:0]   serWord,
  output logic                            serValid,
  // Serial word in
  input  wire logic [sfc_pkg::WORD_BITS-1:0] desWord,
  input  wire logic                       desValid,
  // Parallel output
  output sfc_pkg::sfc_word_t              rxWord,
  output logic [5:0]                      rxGpio,
  output logic                            rxValid,
  input  wire logic                       rxReady,
  // Status
  output logic                            linkLock,
  output logic                            selfTestPass,
  output sfc_pkg::sfc_mode_t              activeMode
);

  // Straps pass two flops before use
  logic [1:0] modeS1_reg, modeS2_reg;
  logic       depthS1_reg, depthS2_reg;
  logic       stS1_reg, stS2_reg;
  logic       modeTaken_reg;                // Mode latched once after reset
  sfc_pkg::sfc_mode_t mode_reg;
  logic       depth18_reg;

  // Synchronisers for the straps; kept out of reset so that they already
  // hold the strap levels when reset is released and the mode is caught
  always_ff @(posedge core_clk) begin
    if (clkEn) begin
      modeS1_reg  <= modePins;
      modeS2_reg  <= modeS1_reg;
      depthS1_reg <= colorDepth18;
      depthS2_reg <= depthS1_reg;
      stS1_reg    <= selfTestEn;
      stS2_reg    <= stS1_reg;
    end
  end

  // Mode is caught after release and held; no register path exists
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      modeTaken_reg <= 1'b0;
      mode_reg      <= sfc_pkg::SFC_NORM_NOFILT;
      depth18_reg   <= 1'b0;
    end else if (clkEn && !modeTaken_reg) begin
      modeTaken_reg <= 1'b1;
      mode_reg      <= sfc_pkg::sfc_mode_t'(modeS2_reg);
      depth18_reg   <= depthS2_reg;
    end
  end

  assign activeMode = mode_reg;
  wire filtOn   = (mode_reg == sfc_pkg::SFC_NORM_FILT);
  wire compatA  = (mode_reg == sfc_pkg::SFC_COMPAT_A);
  wire compatB  = (mode_reg == sfc_pkg::SFC_COMPAT_B);
  wire isNormal = !compatA && !compatB;

  // Control filter per signal: glitch reject then transition budget
  logic [2:0] ctrlIn;
  logic [2:0] ctrlOut;
  assign ctrlIn = {txWord.verticalSync, txWord.horizontalSync, txWord.dataEnable};
  wire  step    = clkEn && txValid && txReady && modeTaken_reg;

  genvar gi;
  generate
    for (gi = 0; gi < sfc_pkg::CTRL_W; gi++) begin : gCtrl
      logic [sfc_pkg::CNT_W-1:0] win_reg;    // Cycles since window start
      logic [1:0]                trCnt_reg;  // Transitions passed this window
      logic [1:0]                stab_reg;   // Run length of a new level
      logic                      out_reg;    // Level sent on the link
      wire  [1:0] maxTr  = (gi == 2) ? 2'(sfc_pkg::CTRL3_MAX_TR) : 2'(sfc_pkg::CTRL12_MAX_TR);
      wire        useMin = filtOn && (gi != 2);
      wire        differs = (ctrlIn[gi] != out_reg);
      // Glitch filter needs the new level for MIN_PULSE clocks
      wire        stable = !useMin || (stab_reg >= 2'(sfc_pkg::MIN_PULSE - 1));
      wire        budget = (trCnt_reg < maxTr);
      wire        take   = differs && stable && budget;
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          win_reg   <= '0;
          trCnt_reg <= 2'h0;
          stab_reg  <= 2'h0;
          out_reg   <= 1'b0;
        end else if (step) begin
          // Window restarts every CTRL_WIN clocks
          if (win_reg == sfc_pkg::CNT_W'(sfc_pkg::CTRL_WIN - 1)) begin
            win_reg   <= '0;
            trCnt_reg <= 2'h0;
          end else begin
            win_reg   <= win_reg + 1'b1;
            trCnt_reg <= trCnt_reg + {1'b0, take};
          end
          if (take) begin
            out_reg <= ctrlIn[gi];
          end
          if (!differs || take) begin
            stab_reg <= 2'h0;
          end else if (stab_reg != 2'h3) begin
            stab_reg <= stab_reg + 1'b1;
          end
        end
      end
      // Legacy modes pass controls untouched
      assign ctrlOut[gi] = isNormal ? out_reg : ctrlIn[gi];
    end
  endgenerate

  // Self-test pattern source: counter advanced once per accepted word
  logic [sfc_pkg::DATA_W-1:0] bistCnt_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bistCnt_reg <= '0;
    end else if (step) begin
      bistCnt_reg <= bistCnt_reg + 1'b1;
    end
  end

  // Payload: data, controls, gpio share in 18-bit mode
  logic [sfc_pkg::DATA_W-1:0] txData;
  logic [sfc_pkg::PAY_W-1:0]  plain;
  assign txData = stS2_reg ? bistCnt_reg :
                  depth18_reg ? {txGpio, txWord.data[17:0]} :
                  txWord.data;
  // 24 data, 1 DC-balance flag, 1 packed control bit position
  // Controls ride only as their parity, in the top bit of the field
  assign plain = {^ctrlOut, txData, 1'b0};

  // Scrambler: LFSR stepped per word on both ends
  logic [sfc_pkg::PAY_W-1:0] txLfsr_reg, rxLfsr_reg;
  function automatic logic [sfc_pkg::PAY_W-1:0] lfsrNext(input logic [sfc_pkg::PAY_W-1:0] s);
    lfsrNext = {s[24:0], s[25] ^ s[5] ^ s[1] ^ s[0]};
  endfunction : lfsrNext

  // DC balance: invert payload when it has more ones than half
  // Bit 0 of the field is the inversion flag the receiver keys on
  wire [sfc_pkg::PAY_W-1:0] scr = plain ^ txLfsr_reg;
  wire [4:0] ones = 5'($countones(scr));
  wire       inv  = (ones > 5'd13);
  wire [sfc_pkg::PAY_W-1:0] bal = inv ? {~scr[sfc_pkg::PAY_W-1:1], 1'b1} :
                                        {scr[sfc_pkg::PAY_W-1:1], 1'b0};

  // Controls kept beside the scrambled field; frame of 28 bits
  logic [2:0] txCtrl_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      serWord    <= '0;
      serValid   <= 1'b0;
      txLfsr_reg <= sfc_pkg::SCR_SEED;
      txCtrl_reg <= 3'h0;
    end else if (clkEn) begin
      serValid <= step;
      if (step) begin
        serWord    <= {sfc_pkg::HI_VAL, bal, sfc_pkg::LO_VAL};
        txLfsr_reg <= lfsrNext(txLfsr_reg);
        txCtrl_reg <= ctrlOut;
      end
    end
  end
  assign txReady = 1'b1;

  // Receiver: marker check, lock after a run of good frames
  wire markOk = desWord[sfc_pkg::HI_POS] == sfc_pkg::HI_VAL &&
                desWord[sfc_pkg::LO_POS] == sfc_pkg::LO_VAL;
  logic [2:0] goodRun_reg;
  wire [sfc_pkg::PAY_W-1:0] rxBal = desWord[sfc_pkg::PAY_W:1];
  wire [sfc_pkg::PAY_W-1:0] rxScr = rxBal[0] ? ~rxBal ^ 26'h1 : rxBal;
  wire [sfc_pkg::PAY_W-1:0] rxPln = rxScr ^ rxLfsr_reg;

  // Lock needs no pattern: any stream with markers counts
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      goodRun_reg <= 3'h0;
      linkLock    <= 1'b0;
      rxLfsr_reg  <= sfc_pkg::SCR_SEED;
    end else if (clkEn && desValid) begin
      if (!markOk) begin
        goodRun_reg <= 3'h0;
        linkLock    <= 1'b0;
      end else if (goodRun_reg != 3'h7) begin
        goodRun_reg <= goodRun_reg + 1'b1;
      end else begin
        linkLock <= 1'b1;
      end
      rxLfsr_reg <= lfsrNext(rxLfsr_reg);
    end
  end

  // Decoded word enters the buffer only while locked
  sfc_pkg::sfc_word_t rxIn;
  assign rxIn.data           = rxPln[sfc_pkg::PAY_W-2:1];
  assign rxIn.verticalSync   = txCtrl_reg[2];
  assign rxIn.horizontalSync = txCtrl_reg[1];
  assign rxIn.dataEnable     = txCtrl_reg[0];
  wire bufIn = clkEn && desValid && markOk && linkLock;
  logic [26:0] bufOut;

  sfc_buf2 #(.W(27)) uBuf (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .inValid  (bufIn),
    .inReady  (),             // No link back-pressure: a full buffer drops
    .inData   (rxIn),
    .outValid (rxValid),
    .outReady (rxReady),
    .outData  (bufOut)
  );

  // Self-test compare against the rx pattern counter
  logic [sfc_pkg::DATA_W-1:0] rxCnt_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxCnt_reg    <= '0;
      selfTestPass <= 1'b0;
    end else if (bufIn) begin
      rxCnt_reg    <= rxIn.data + 1'b1;
      selfTestPass <= stS2_reg && (rxIn.data == rxCnt_reg);
    end
  end

  assign rxWord = bufOut;
  assign rxGpio = depth18_reg ? bufOut[26:21] : 6'h0;

  // Markers always correct on every frame sent
  chk_marker_bits: assert property (@(posedge core_clk) disable iff (!rst_n)
    serValid |-> serWord[27] && !serWord[0]) else $error("marker wrong");
  // Balanced field never carries more than half ones
  chk_dc_balance: assert property (@(posedge core_clk) disable iff (!rst_n)
    serValid |-> $countones(serWord[26:2]) <= 13) else $error("unbalanced");
  // Mode frozen once taken
  chk_mode_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    modeTaken_reg && $past(modeTaken_reg) |-> $stable(mode_reg)) else $error("mode moved");
  // Control three never exceeds budget
  chk_ctrl3_budget: assert property (@(posedge core_clk) disable iff (!rst_n)
    gCtrl[2].trCnt_reg <= 2'h1) else $error("ctrl3 budget");
  // Controls one and two stay within two transitions
  chk_ctrl12_budget: assert property (@(posedge core_clk) disable iff (!rst_n)
    gCtrl[0].trCnt_reg <= 2'h2 && gCtrl[1].trCnt_reg <= 2'h2) else $error("ctrl budget");
  // Filter on: a one-cycle glitch on control two is never taken
  chk_glitch_reject: assert property (@(posedge core_clk) disable iff (!rst_n)
    filtOn && gCtrl[1].take |-> gCtrl[1].stab_reg >= 2'h2) else $error("glitch passed");
  // Lock drops the cycle after a bad marker
  chk_lock_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
    clkEn && desValid && !markOk |=> !linkLock) else $error("lock kept");
  // Word out follows accepted word
  chk_ser_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    clkEn && step |=> serValid) else $error("no frame");
  // Legacy mode disables filtering
  chk_compat_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
    compatA || compatB |-> ctrlOut == ctrlIn) else $error("compat filtered");

endmodule : sfc_frame_ctrl

/* include/sfc_pkg.sv */
package sfc_pkg;

  // Frame geometry
  localparam int DATA_W    = 24;
  localparam int CTRL_W    = 3;
  localparam int PAY_W     = 26;
  localparam int WORD_BITS = 28;
  localparam int HI_POS    = 27;
  localparam int LO_POS    = 0;
  localparam logic HI_VAL  = 1'b1;
  localparam logic LO_VAL  = 1'b0;

  // Line rate limits in Mbps
  localparam int RATE_MIN_MBPS = 140;
  localparam int RATE_MAX_MBPS = 1400;

  // Control filter timing in parallel clocks
  localparam int CTRL_WIN       = 130;
  localparam int CTRL12_MAX_TR  = 2;
  localparam int CTRL3_MAX_TR   = 1;
  localparam int MIN_PULSE      = 3;
  localparam int CNT_W          = 8;

  // Scrambler seed
  localparam logic [PAY_W-1:0] SCR_SEED = 26'h2a5_5a5a;

  // Mode decode of the two select pins
  typedef enum logic [1:0] {
    SFC_NORM_NOFILT = 2'h0,
    SFC_NORM_FILT   = 2'h1,
    SFC_COMPAT_A    = 2'h2,
    SFC_COMPAT_B    = 2'h3
  } sfc_mode_t;

  // One parallel word with its controls
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              verticalSync;
    logic              horizontalSync;
    logic              dataEnable;
  } sfc_word_t;

endpackage : sfc_pkg

/* core/sfc_buf2.sv */
`timescale 1ns/100ps
// Two-entry skid buffer; when full it drops inReady and takes no new word
module sfc_buf2 #(
  parameter int W = 27
) (
  // Clock and control
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  // Fill side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // Drain side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);

  logic [W-1:0] mem_reg [2];    // Storage entries
  logic         wrPtr_reg;      // Write index
  logic         rdPtr_reg;      // Read index
  logic [1:0]   count_reg;      // Occupancy
  wire          doWr = inValid && inReady;
  wire          doRd = outValid && outReady;

  assign inReady  = (count_reg != 2'h2);
  assign outValid = (count_reg != 2'h0);
  assign outData  = mem_reg[rdPtr_reg];

  // Pointer and occupancy update
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else if (clkEn) begin
      if (doWr) begin
        mem_reg[wrPtr_reg] <= inData;
        wrPtr_reg          <= ~wrPtr_reg;
      end
      if (doRd) begin
        rdPtr_reg <= ~rdPtr_reg;
      end
      count_reg <= count_reg + {1'b0, doWr} - {1'b0, doRd};
    end
  end

endmodule : sfc_buf2

/* tb/sfc_peer_model.sv */
`timescale 1ns/100ps
// Far end of the link: hands each frame straight back, as a matched peer would
module sfc_peer_model (
  // Clock
  core_clk,
  // Frames from the block
  serWord,
  serValid,
  // Fault command from the bench
  breakMarker,
  // Frames back to the block
  desWord,
  desValid,
  frameErr
);
  input  wire logic                          core_clk;
  input  wire logic [sfc_pkg::WORD_BITS-1:0] serWord;
  input  wire logic                          serValid;
  input  wire logic                          breakMarker;
  output logic      [sfc_pkg::WORD_BITS-1:0] desWord;
  output logic                               desValid;
  output logic                               frameErr;

  logic errSeen = 1'b0;  // Sticky marker fault

  // Idle line shows the inverse, so a stale frame never passes for a fresh one
  assign desWord  = serValid ? (serWord ^ {breakMarker, 27'h0}) : ~serWord;
  assign desValid = serValid;  // One frame per word
  assign frameErr = errSeen;

  // Flag any frame arriving with a wrong marker
  always @(posedge core_clk) begin
    if (serValid && (serWord[27] !== 1'b1 || serWord[0] !== 1'b0)) begin
      errSeen <= 1'b1;
    end
  end
endmodule : sfc_peer_model

/* tb/tb_top.sv */
`timescale 1ns/100ps
// Loopback bench: the block faces the peer model
module tb_top;
  // Clock, reset, straps
  logic               core_clk;
  logic               rst_n;
  logic [1:0]         modePins;
  logic               colorDepth18;
  logic               selfTestEn;
  logic [5:0]         txGpio;
  logic [5:0]         rxGpio;
  logic               selfTestPass;
  // Parallel sides
  sfc_pkg::sfc_word_t txWord;
  sfc_pkg::sfc_word_t rxWord;
  logic               txValid;
  logic               txReady;
  logic               rxValid;
  logic               rxReady;
  // Link and status
  logic [27:0]        serWord;
  logic [27:0]        desWord;
  logic               serValid;
  logic               desValid;
  logic               breakMarker;
  logic               frameErr;
  logic               linkLock;
  sfc_pkg::sfc_mode_t activeMode;
  // Bookkeeping
  int                 num_errors = 0;
  int                 n_tests = 0;
  logic               hsSeen;
  logic               lastVs;
  int                 vsEdges;

  sfc_frame_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1), .modePins(modePins),
    .colorDepth18(colorDepth18), .selfTestEn(selfTestEn), .txWord(txWord), .txGpio(txGpio),
    .txValid(txValid), .txReady(txReady), .serWord(serWord), .serValid(serValid),
    .desWord(desWord), .desValid(desValid), .rxWord(rxWord), .rxGpio(rxGpio),
    .rxValid(rxValid), .rxReady(rxReady), .linkLock(linkLock),
    .selfTestPass(selfTestPass), .activeMode(activeMode));

  sfc_peer_model peer (.core_clk(core_clk), .serWord(serWord), .serValid(serValid),
    .breakMarker(breakMarker), .desWord(desWord), .desValid(desValid), .frameErr(frameErr));

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Watch words accepted at the receive side for control activity
  always @(posedge core_clk) begin
    if (rxValid && rxReady) begin
      hsSeen <= hsSeen | rxWord.horizontalSync;
      if (rxWord.verticalSync !== lastVs) begin
        vsEdges <= vsEdges + 1;
      end
      lastVs <= rxWord.verticalSync;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Reset with straps held well before release; returns two edges later
  task automatic do_reset(input logic [1:0] m);
    rst_n = 1'b0;
    modePins = m;
    txValid = 1'b0;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    hsSeen = 1'b0;
    lastVs = 1'b0;
    vsEdges = 0;
  endtask : do_reset

  // Offer one word; returns at the next falling edge with valid still up
  task automatic put(input logic [23:0] d, input logic [2:0] c);
    txWord = {d, c};
    txValid = 1'b1;
    @(negedge core_clk);
  endtask : put

  task automatic idle(input int n);
    txValid = 1'b0;
    repeat (n) @(negedge core_clk);
  endtask : idle

  // Enough good frames to lock, then drain whatever got through
  task automatic lock();
    repeat (10) put(24'h0, 3'h0);
    idle(4);
    check(linkLock, 1'b1);
  endtask : lock

  // Every mode code decodes, valids and lock clear with txReady up, strap changes later ignored
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1:0]);
      check({serValid, rxValid, linkLock, txReady}, 4'h1);
      check(activeMode, m);
      modePins = ~m[1:0];
      repeat (3) @(negedge core_clk);
      check(activeMode, m);
    end
  endtask : t_modes

  // Back-to-back frames carry both markers, one valid per word
  task automatic t_frame();
    do_reset(2'h0);
    for (int i = 0; i < 4; i++) begin
      put(24'hc3a500 + i, 3'h0);
      check({serValid, serWord[27], serWord[0]}, 3'h6);
    end
    idle(1);
    check(serValid, 1'b0);
    check(frameErr, 1'b0);
  endtask : t_frame

  // Data survives the link; a broken marker drops lock and the frame
  task automatic t_data();
    int k;
    lock();
    put(24'h5a3ce1, 3'h0);
    idle(0);
    k = 0;
    while (rxValid !== 1'b1 && k < 8) begin
      @(negedge core_clk);
      k++;
    end
    check(rxWord.data, 24'h5a3ce1);
    idle(2);
    breakMarker = 1'b1;
    put(24'h123456, 3'h0);
    idle(1);
    breakMarker = 1'b0;
    check({linkLock, rxValid}, 2'h0);
  endtask : t_data

  // Receiver stall: two words kept in order, the third lost
  task automatic t_stall();
    lock();
    rxReady = 1'b0;
    put(24'h0000aa, 3'h0);
    put(24'h0000bb, 3'h0);
    put(24'h0000cc, 3'h0);
    idle(6);
    check({rxValid, rxWord.data}, {1'b1, 24'h0000aa});
    rxReady = 1'b1;
    @(negedge core_clk);
    check({rxValid, rxWord.data}, {1'b1, 24'h0000bb});
    @(negedge core_clk);
    check(rxValid, 1'b0);
  endtask : t_stall

  // One-word sync glitch plus a short pulse on control three
  task automatic pulses();
    lock();
    hsSeen = 1'b0;
    vsEdges = 0;
    put(24'h0, 3'h2);
    repeat (4) put(24'h0, 3'h4);
    repeat (12) put(24'h0, 3'h0);
    idle(6);
  endtask : pulses

  // Filter on rejects the glitch; filter off passes it
  task automatic t_filter();
    do_reset(2'h1);
    pulses();
    check(hsSeen, 1'b0);
    repeat (4) put(24'h0, 3'h2);
    idle(6);
    check(hsSeen, 1'b1);
    do_reset(2'h0);
    pulses();
    check(hsSeen, 1'b1);
    check(vsEdges, 1);
    do_reset(2'h2);
    pulses();
    check({hsSeen, vsEdges[3:0]}, 5'h12);
  endtask : t_filter

  // 18-bit packing carries gpio in the top data bits; self-test pattern checks
  task automatic t_straps();
    colorDepth18 = 1'b1;
    do_reset(2'h0);
    lock();
    txGpio = 6'h2d;
    put(24'h3c0555, 3'h0);
    idle(1);
    check({rxValid, rxGpio, rxWord.data[17:0]}, {1'b1, 6'h2d, 18'h00555});
    check(selfTestPass, 1'b0);
    txGpio = 6'h00;
    colorDepth18 = 1'b0;
    selfTestEn = 1'b1;
    do_reset(2'h0);
    lock();
    check(selfTestPass, 1'b1);
    selfTestEn = 1'b0;
  endtask : t_straps

  // Main sequence
  initial begin
    rst_n = 1'b0;
    modePins = 2'h0;
    colorDepth18 = 1'b0;
    selfTestEn = 1'b0;
    txGpio = 6'h00;
    txWord = '0;
    txValid = 1'b0;
    rxReady = 1'b1;
    breakMarker = 1'b0;
    t_modes();
    t_frame();
    t_data();
    t_stall();
    t_straps();
    t_filter();
    print_verdict();
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end
endmodule : tb_top
